//--- src/hcd_sink_driver.v
// Sink driver control with atomic port bit updates on an Avalon-MM slave
`timescale 1ns/1ps
`include "hcd_regs.vh"

module hcd_sink_driver (
    // Clock and reset
    input  wire        clock,
    input  wire        reset_n,
    // Avalon-MM slave
    input  wire [5:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    // Open-drain sink driver pins
    input  wire [3:0]  sink_pin_in,
    output reg  [3:0]  sink_pin_out,
    output reg  [3:0]  sink_pin_oe_n,
    // Adapter port B and configuration
    output reg  [7:0]  adapter_port_b_byte,
    output reg  [7:0]  adapter_cfg,
    // Interrupt hold toward the processor
    output reg         irq_hold,
    // Atomic 32-bit value
    output reg  [31:0] wide_value
);

    // Wait-state lengths, cut to the counter width
    localparam integer RMW_CYC = `HCD_RMW_CYC;
    localparam integer ADP_CYC = `HCD_ADP_CYC;
    localparam [9:0]   RMW_LEN = RMW_CYC[9:0] - 10'h001;
    localparam [9:0]   ADP_LEN = ADP_CYC[9:0] - 10'h001;

    // Driver zero and access sequencer state
    reg        sink_driver_zero_r;
    reg        busy_r;
    reg        hold_r;
    reg  [9:0] cnt_r;
    reg  [5:0] addr_r;

    // Halves of the atomic value
    reg [15:0] wide_stage_r;
    reg [15:0] wide_snap_r;

    // Pin synchroniser stages
    reg  [3:0] pin_meta_r;
    reg  [3:0] pin_sync_r;

    // Decode and next values
    reg  [9:0] len;
    reg        atomic;
    reg [31:0] rd_mux;
    reg  [3:0] drv_nxt;
    reg  [7:0] pb_nxt;

    // Handshake terms
    wire       req;
    wire       done;
    wire       wr_done;
    wire       hold_start;
    wire [31:0] wd;

    // Driver views
    wire [3:0] drv_state;
    wire       sink_driver_one;
    wire       sink_driver_three;

    // Masked bit update: 0 set, 1 clear, 2 toggle, 3 change
    function [7:0] bit_update;
        input [7:0] old;
        input [7:0] mask;
        input [7:0] val;
        input [1:0] op;
        begin
            case (op)
                2'h0:    bit_update = old | mask;
                2'h1:    bit_update = old & ~mask;
                2'h2:    bit_update = old ^ mask;
                default: bit_update = (old & ~mask) | (val & mask);
            endcase
        end
    endfunction

    // Byte lane merge for stored halves
    function [15:0] lane_merge;
        input [15:0] old;
        input [15:0] new_val;
        input [1:0]  be;
        begin
            lane_merge[7:0]  = be[0] ? new_val[7:0]  : old[7:0];
            lane_merge[15:8] = be[1] ? new_val[15:8] : old[15:8];
        end
    endfunction

    // Write data with disabled byte lanes zeroed
    assign wd = avs_writedata & {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                                 {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // Driver state view: zero from logic, one to three from port B
    assign drv_state = {adapter_port_b_byte[7:`HCD_PB_DRV_LSB], sink_driver_zero_r}; // R04
    assign sink_driver_one   = drv_state[1];
    assign sink_driver_three = drv_state[3];

    // Bus handshake
    assign req             = avs_read | avs_write;
    assign done            = busy_r & (cnt_r == 10'h000) & req;
    assign wr_done         = done & avs_write;
    assign hold_start      = req & ~busy_r & atomic;
    assign avs_waitrequest = req & ~done;

    // Access length and interrupt hold class per address
    always @* begin
        len    = 10'h000;
        atomic = 1'b0;
        case (avs_address)
            `HCD_DRV_SET, `HCD_DRV_CLR: begin
                len    = RMW_LEN; // R09
                atomic = 1'b1;    // R08
            end
            `HCD_PORTB, `HCD_PORTB_SET, `HCD_PORTB_CLR,
            `HCD_PORTB_TOG, `HCD_PORTB_CHG, `HCD_ADAPTER_CFG: begin
                len    = ADP_LEN; // R11
                atomic = 1'b1;    // R11
            end
            default: begin
                len    = 10'h000;
                atomic = 1'b0;
            end
        endcase
    end

    // Read data selection
    // Decoded from the held bus address so a read with one wait state is ready in time
    always @* begin
        rd_mux = 32'h0000_0000;
        case (avs_address)
            `HCD_DRV_CTRL:    rd_mux[3:0]  = drv_state;
            `HCD_PORTB:       rd_mux[7:0]  = adapter_port_b_byte;
            `HCD_ADAPTER_CFG: rd_mux[7:0]  = adapter_cfg;
            `HCD_WIDE_LO:     rd_mux[15:0] = wide_value[15:0];
            `HCD_WIDE_HI:     rd_mux[15:0] = wide_snap_r; // R10
            `HCD_STATUS: begin
                rd_mux[`HCD_ST_BUSY] = busy_r;
                rd_mux[`HCD_ST_HOLD] = hold_r;
                rd_mux[`HCD_ST_PIN_LSB+3:`HCD_ST_PIN_LSB] = pin_sync_r;
            end
            default:          rd_mux = 32'h0000_0000;
        endcase
    end

    // Next driver and port B values for the finishing write
    always @* begin
        drv_nxt = drv_state;
        pb_nxt  = adapter_port_b_byte;
        case (addr_r)
            `HCD_DRV_CTRL: begin
                if (avs_byteenable[0]) begin
                    drv_nxt = avs_writedata[3:0];
                end
            end
            `HCD_DRV_SET: drv_nxt = drv_state | wd[3:0];  // R01
            `HCD_DRV_CLR: drv_nxt = drv_state & ~wd[3:0]; // R02 R03
            `HCD_PORTB: begin
                if (avs_byteenable[0]) begin
                    pb_nxt = avs_writedata[7:0];
                end
            end
            `HCD_PORTB_SET: pb_nxt = bit_update(adapter_port_b_byte, wd[7:0], 8'h00, 2'h0); // R07
            `HCD_PORTB_CLR: pb_nxt = bit_update(adapter_port_b_byte, wd[7:0], 8'h00, 2'h1); // R07
            `HCD_PORTB_TOG: pb_nxt = bit_update(adapter_port_b_byte, wd[7:0], 8'h00, 2'h2); // R07
            `HCD_PORTB_CHG: pb_nxt = bit_update(adapter_port_b_byte, wd[15:8], wd[7:0],
                                                2'h3); // R07
            default: begin
                drv_nxt = drv_state;
                pb_nxt  = adapter_port_b_byte;
            end
        endcase
        if (addr_r == `HCD_DRV_CTRL || addr_r == `HCD_DRV_SET || addr_r == `HCD_DRV_CLR) begin
            pb_nxt[7:`HCD_PB_DRV_LSB] = drv_nxt[3:1]; // R04
        end
    end

    // Access sequencer: wait states and interrupt hold
    // Counter loads at the request edge and counts down to the answer
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            busy_r <= 1'b0;
            hold_r <= 1'b0;
            cnt_r  <= 10'h000;
            addr_r <= 6'h00;
        end else if (req && !busy_r) begin
            busy_r <= 1'b1;
            hold_r <= atomic; // R08
            cnt_r  <= len;
            addr_r <= avs_address;
        end else if (done) begin
            busy_r <= 1'b0;
            hold_r <= 1'b0; // R08
        end else if (busy_r && cnt_r != 10'h000) begin
            cnt_r <= cnt_r - 10'h001;
        end
    end

    // Interrupt hold output
    // Rises the cycle after the request starts, falls the cycle after the answer
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irq_hold <= 1'b0;
        end else begin
            irq_hold <= (hold_r & ~done) | hold_start; // R08 R09 R11
        end
    end

    // Read data register, loaded while the request waits
    // Holds still at the answering edge, so the master takes a settled word
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (req && !done) begin
            avs_readdata <= rd_mux;
        end
    end

    // Driver zero from logic, reset off
    // Async reset keeps it off from the first instant of power-up
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sink_driver_zero_r <= `HCD_DRV0_RST; // R05 R13
        end else if (wr_done) begin
            sink_driver_zero_r <= drv_nxt[0]; // R01 R02 R03
        end
    end

    // Adapter port B and configuration
    // A configuration write clears the port even with an unchanged value
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            adapter_port_b_byte <= `HCD_PORTB_RST; // R13
            adapter_cfg         <= `HCD_CFG_RST;
        end else if (wr_done) begin
            if (addr_r == `HCD_ADAPTER_CFG) begin
                if (avs_byteenable[0]) begin
                    adapter_cfg <= avs_writedata[7:0];
                end
                adapter_port_b_byte <= 8'h00; // R12
            end else begin
                adapter_port_b_byte <= pb_nxt;
            end
        end
    end

    // Atomic 32-bit value: low half staged, high half commits both
    // A reader sees the high half frozen when it reads the low half
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wide_stage_r <= 16'h0000;
            wide_snap_r  <= 16'h0000;
            wide_value   <= 32'h0000_0000;
        end else if (done) begin
            if (avs_write && addr_r == `HCD_WIDE_LO) begin
                wide_stage_r <= lane_merge(wide_stage_r, avs_writedata[15:0],
                                           avs_byteenable[1:0]); // R10
            end
            if (avs_write && addr_r == `HCD_WIDE_HI) begin
                wide_value <= {lane_merge(wide_value[31:16], avs_writedata[15:0],
                                          avs_byteenable[1:0]), wide_stage_r}; // R10
            end
            if (avs_read && addr_r == `HCD_WIDE_LO) begin
                wide_snap_r <= wide_value[31:16]; // R10
            end
        end
    end

    // Pin level synchroniser for status readback
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pin_meta_r <= 4'h0;
            pin_sync_r <= 4'h0;
        end else begin
            pin_meta_r <= sink_pin_in;
            pin_sync_r <= pin_meta_r;
        end
    end

    // Open-drain drive: on pulls low, off releases the pin
    // Registered so no decode glitch can briefly switch a driver on
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sink_pin_out  <= 4'h0;
            sink_pin_oe_n <= 4'hF; // R05
        end else begin
            sink_pin_out     <= 4'h0;                // R06
            sink_pin_oe_n[0] <= ~sink_driver_zero_r; // R06
            sink_pin_oe_n[1] <= ~sink_driver_one;    // R06
            sink_pin_oe_n[2] <= ~drv_state[2];       // R06
            sink_pin_oe_n[3] <= ~sink_driver_three;  // R06
        end
    end

endmodule // hcd_sink_driver

//--- src/hcd_regs.vh
// Register map, field positions and timing counts of the sink driver block
// How it works
// R01: A set command takes a 4-bit mask and switches on each driver whose mask bit is one.
// R02: A clear command takes a 4-bit mask and switches off each driver whose mask bit is one.
// R03: Clearing drivers through a mask leaves every other driver exactly as it was.
// R04: Drivers one to three follow port B bits five to seven; driver zero follows a logic bit.
// R05: Driver zero is off from power-up and through reset without any glitch.
// R06: An enabled driver pulls its pin low; a disabled one lets the pin float high.
// R07: A masked port update changes only the selected bits and keeps all the others.
// R08: Masked updates hold interrupts off before the read and release them after the write.
// R09: Each atomic bit update holds interrupts off for ten to sixteen 8 MHz cycles; the code holds 10 for driver set and clear, 27 for port B updates.
// R10: A 32-bit value is written and read as two 16-bit halves that never tear.
// R11: Every adapter port access adds wait states and holds interrupts off for 27 cycles.
// R12: Any write to the adapter configuration register drives every adapter output low.
// R13: After reset all four driver control bits read zero, so every driver is off.
`ifndef HCD_REGS_VH
`define HCD_REGS_VH

// Byte offsets on the register bus
`define HCD_DRV_CTRL     6'h00
`define HCD_DRV_SET      6'h04
`define HCD_DRV_CLR      6'h08
`define HCD_PORTB        6'h0C
`define HCD_PORTB_SET    6'h10
`define HCD_PORTB_CLR    6'h14
`define HCD_PORTB_TOG    6'h18
`define HCD_PORTB_CHG    6'h1C
`define HCD_ADAPTER_CFG  6'h20
`define HCD_WIDE_LO      6'h24
`define HCD_WIDE_HI      6'h28
`define HCD_STATUS       6'h2C

// Field positions
`define HCD_DRV_W        4
`define HCD_PB_DRV_LSB   5
`define HCD_CHG_MASK_LSB 8
`define HCD_ST_BUSY      0
`define HCD_ST_HOLD      1
`define HCD_ST_PIN_LSB   4

// Reset values
`define HCD_DRV0_RST     1'b0
`define HCD_PORTB_RST    8'h00
`define HCD_CFG_RST      8'h00

// Timing: one 8 MHz cycle is 125 ns, bus clock 200 MHz
`define HCD_CLK_MHZ      200
`define HCD_XTAL_NS      125
`define HCD_RMW_HOLD_NS  (10 * `HCD_XTAL_NS)
`define HCD_ADP_HOLD_NS  (27 * `HCD_XTAL_NS)
`define HCD_RMW_CYC      ((`HCD_RMW_HOLD_NS * `HCD_CLK_MHZ + 999) / 1000)
`define HCD_ADP_CYC      ((`HCD_ADP_HOLD_NS * `HCD_CLK_MHZ + 999) / 1000)

`endif

//--- verification/hcd_load_model.sv
// Pulled-up external load on the four open-drain sink driver pins
`timescale 1ns/1ps

module hcd_load_model (
    // Driver side
    input  wire logic [3:0] sink_pin_out,
    input  wire logic [3:0] sink_pin_oe_n,
    // Pin levels seen by the block
    output wire logic [3:0] pin_level
);
    // Released pin floats high through the load, enabled pin sinks low
    assign pin_level = sink_pin_oe_n | sink_pin_out;
endmodule // hcd_load_model

//--- verification/hcd_sink_driver_asserts.sv
// Concurrent checks on the sink driver block ports
`timescale 1ns/1ps
`include "hcd_regs.vh"

module hcd_sink_driver_asserts (
    // Clock and reset
    input wire logic        clock,
    input wire logic        reset_n,
    // Register bus
    input wire logic [5:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic        avs_waitrequest,
    // Pins and outputs
    input wire logic [3:0]  sink_pin_out,
    input wire logic [3:0]  sink_pin_oe_n,
    input wire logic [7:0]  adapter_port_b_byte,
    input wire logic        irq_hold,
    input wire logic [31:0] wide_value
);
    logic [11:0] wait_r;
    wire         acc = avs_write && !avs_waitrequest;
    wire         drv = avs_address == `HCD_DRV_SET || avs_address == `HCD_DRV_CLR;
    wire         lng = (avs_read || avs_write) && avs_address >= 6'h04 && avs_address <= 6'h20;

    // Wait cycles of the request in progress
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) wait_r <= 12'h000;
        else if ((avs_read || avs_write) && avs_waitrequest) wait_r <= wait_r + 12'h001;
        else wait_r <= 12'h000;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    pins_low_a: assert property (sink_pin_out == 4'h0) else $error("pin out not low");
    drv_map_a: assert property (sink_pin_oe_n[3:1] == ~$past(adapter_port_b_byte[7:5]))
        else $error("drivers 1-3 differ from port b");
    drv0_reset_a: assert property (disable iff (1'b0) !reset_n |-> sink_pin_oe_n[0])
        else $error("driver 0 on in reset");
    set_mask_a: assert property (acc && avs_address == `HCD_DRV_SET && avs_byteenable[0]
        |=> ##1 sink_pin_oe_n == ($past(sink_pin_oe_n, 2) & ~$past(avs_writedata[3:0], 2)))
        else $error("set mask result wrong");
    clr_mask_a: assert property (acc && avs_address == `HCD_DRV_CLR && avs_byteenable[0]
        |=> ##1 sink_pin_oe_n == ($past(sink_pin_oe_n, 2) | $past(avs_writedata[3:0], 2)))
        else $error("clear mask result wrong");
    pb_set_a: assert property (acc && avs_address == `HCD_PORTB_SET && avs_byteenable[0]
        |=> adapter_port_b_byte == ($past(adapter_port_b_byte) | $past(avs_writedata[7:0])))
        else $error("port set result wrong");
    cfg_zero_a: assert property (acc && avs_address == `HCD_ADAPTER_CFG
        |=> adapter_port_b_byte == 8'h00) else $error("port not zeroed by cfg");
    atom_span_a: assert property (acc && drv |-> wait_r >= 12'h0FA && wait_r <= 12'h190)
        else $error("atomic hold length wrong");
    adp_span_a: assert property (lng && !drv && !avs_waitrequest |-> wait_r >= 12'h2A3)
        else $error("adapter access too short");
    hold_mid_a: assert property (lng && avs_waitrequest && wait_r != 12'h000 |-> irq_hold)
        else $error("interrupts not held");
    hold_end_a: assert property (lng && !avs_waitrequest |=> !irq_hold)
        else $error("interrupt hold not released");
    wide_still_a: assert property (!(acc && avs_address == `HCD_WIDE_HI)
        |=> $stable(wide_value)) else $error("wide value torn");
endmodule // hcd_sink_driver_asserts

//--- verification/tb.sv
// Self-checking bench for the sink driver block
`timescale 1ns/1ps
`include "hcd_regs.vh"

module tb;
    logic        clock = 1'b0;
    logic        reset_n = 1'b1;
    logic [5:0]  avs_address = 6'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hF;
    wire  [31:0] avs_readdata, wide_value;
    wire         avs_waitrequest, irq_hold;
    wire  [3:0]  pin_level, sink_pin_out, sink_pin_oe_n;
    wire  [7:0]  port_b, cfg;
    int          mismatches = 0;
    int          checked = 0;
    logic [31:0] q;
    logic [5:0]  ops [5] = '{`HCD_PORTB, `HCD_PORTB_SET, `HCD_PORTB_CLR,
                             `HCD_PORTB_TOG, `HCD_PORTB_CHG};
    logic [31:0] dat [5] = '{32'h5A, 32'h81, 32'h18, 32'h0F, 32'hF03A};
    logic [31:0] exq [5] = '{32'h5A, 32'hDB, 32'hC3, 32'hCC, 32'h3C};

    always #2.5 clock = ~clock;

    hcd_sink_driver u_dut (.clock(clock), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sink_pin_in(pin_level), .sink_pin_out(sink_pin_out),
        .sink_pin_oe_n(sink_pin_oe_n), .adapter_port_b_byte(port_b), .adapter_cfg(cfg),
        .irq_hold(irq_hold), .wide_value(wide_value));
    hcd_load_model u_load (.sink_pin_out(sink_pin_out), .sink_pin_oe_n(sink_pin_oe_n),
        .pin_level(pin_level));

    // Compare and count
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    // Bus write, held until waitrequest is sampled low
    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= 1'b1;
        @(posedge clock);
        while (avs_waitrequest !== 1'b0) @(posedge clock);
        avs_write <= 1'b0;
    endtask

    // Bus read, data taken at the accepting edge
    task automatic rd(input logic [5:0] a);
        @(posedge clock);
        avs_address <= a;
        avs_read <= 1'b1;
        @(posedge clock);
        while (avs_waitrequest !== 1'b0) @(posedge clock);
        q = avs_readdata;
        avs_read <= 1'b0;
    endtask

    task automatic rc(input logic [5:0] a, input logic [31:0] e, input string n);
        rd(a);
        chk(n, e, q);
    endtask

    task automatic end_of_test;
        $display("Comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Watchdog well beyond the expected run
    initial begin
        #200000;
        mismatches++;
        end_of_test;
    end

    // Test sequence
    initial begin
        #1 reset_n = 1'b0;
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        rc(`HCD_DRV_CTRL, 32'h0, "ctrl after reset");
        chk("oe_n after reset", 32'hF, 32'(sink_pin_oe_n));
        $display("Test reset done");
        wr(`HCD_DRV_SET, 32'hF, 4'h0);
        rc(`HCD_DRV_CTRL, 32'h0, "ctrl lane off");
        wr(`HCD_DRV_SET, 32'hF);
        rc(`HCD_DRV_CTRL, 32'hF, "ctrl set");
        wr(`HCD_DRV_CLR, 32'h1);
        rc(`HCD_DRV_CTRL, 32'hE, "ctrl clear");
        @(negedge clock);
        chk("port b drivers", 32'h7, 32'(port_b[7:5]));
        repeat (4) @(posedge clock);
        rd(`HCD_STATUS);
        chk("pin levels", 32'h1, 32'(q[7:4]));
        wr(`HCD_PORTB, 32'hA0);
        rc(`HCD_DRV_CTRL, 32'hA, "ctrl from port b");
        $display("Test drivers done");
        for (int i = 0; i < 5; i++) begin
            wr(ops[i], dat[i]);
            rc(`HCD_PORTB, exq[i], "port b update");
        end
        wr(`HCD_ADAPTER_CFG, 32'h12);
        rc(`HCD_PORTB, 32'h0, "port b after cfg");
        rc(`HCD_ADAPTER_CFG, 32'h12, "cfg");
        $display("Test port done");
        wr(`HCD_WIDE_LO, 32'h1234);
        @(negedge clock);
        chk("wide staged", 32'h0, wide_value);
        wr(`HCD_WIDE_HI, 32'hABCD);
        @(negedge clock);
        chk("wide value", 32'hABCD1234, wide_value);
        rc(`HCD_WIDE_LO, 32'h1234, "wide low");
        rc(`HCD_WIDE_HI, 32'hABCD, "wide high");
        wr(6'h3C, 32'h55);
        rc(6'h3C, 32'h0, "unmapped");
        $display("Test wide done");
        end_of_test;
    end
endmodule // tb

bind hcd_sink_driver hcd_sink_driver_asserts u_chk (.clock(clock), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_waitrequest(avs_waitrequest), .sink_pin_out(sink_pin_out),
    .sink_pin_oe_n(sink_pin_oe_n), .adapter_port_b_byte(adapter_port_b_byte),
    .irq_hold(irq_hold), .wide_value(wide_value));
